// ==== hw/lqm_monitor.sv ====
// Link quality monitor: threshold compare, warnings, restart and interrupt.
// Assumes DSP values, link valid and signal-detect option come from ref_clk logic.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ns

module lqm_monitor (
	// Clock and reset
	input  wire logic                          ref_clk,
	input  wire logic                          reset_n,
	// Register port
	input  wire lqm_pkg::lqm_bus_req_t         bus_req,
	output logic [lqm_pkg::DATA_W-1:0]         bus_rdata,
	// Receiver side
	input  wire lqm_pkg::lqm_dsp_t             dsp_values,
	input  wire logic                          link_valid_100,
	input  wire logic                          signal_detect_option,
	output logic                               dsp_restart,
	output logic                               link_drop,
	// Interrupt
	output logic                               irq
);
	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic                          rst_meta_q;
	logic                          rst_n_q;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic                          enable_q;
	logic [lqm_pkg::NPARAM-1:0]    restart_en_q;
	logic [lqm_pkg::WARN_W-1:0]    warn_q;
	logic [lqm_pkg::WARN_W-1:0]    warn_d;
	lqm_pkg::lqm_val_t             thr_lo_q [lqm_pkg::NPARAM];
	lqm_pkg::lqm_val_t             thr_hi_q [lqm_pkg::NPARAM];
	logic [2:0]                    thr_sel_q;
	logic                          thr_lvl_q;
	logic                          armed_q;
	logic                          armed_d;
	logic [lqm_pkg::IRQ_W-1:0]     istat_q;
	logic [lqm_pkg::IRQ_W-1:0]     istat_d;
	logic [lqm_pkg::IRQ_W-1:0]     imask_q;
	logic [lqm_pkg::DATA_W-1:0]    rdata_q;
	logic [lqm_pkg::DATA_W-1:0]    rdata_d;
	logic                          restart_q;
	logic                          drop_q;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [lqm_pkg::ADDR_W-1:0] a,
		input logic [lqm_pkg::ADDR_W-1:0] r);
		hit = (a == r);
	endfunction

	wire                           rd_ctrl   = bus_req.re & hit(bus_req.addr,
		lqm_pkg::ADDR_CTRL_STATUS);
	wire                           wr_ctrl   = bus_req.we & hit(bus_req.addr,
		lqm_pkg::ADDR_CTRL_STATUS);
	wire                           wr_thr    = bus_req.we & hit(bus_req.addr,
		lqm_pkg::ADDR_THRESHOLD);
	wire                           wr_istat  = bus_req.we & hit(bus_req.addr,
		lqm_pkg::ADDR_IRQ_STATUS);
	wire                           wr_imask  = bus_req.we & hit(bus_req.addr,
		lqm_pkg::ADDR_IRQ_MASK);
	wire [2:0]                     wr_sel    = bus_req.wdata[lqm_pkg::THR_SEL_LSB +: 3];
	wire                           wr_lvl    = bus_req.wdata[lqm_pkg::THR_LVL_BIT];
	wire lqm_pkg::lqm_val_t        wr_val    = bus_req.wdata[lqm_pkg::VAL_W-1:0];

	// ----------------------------------------------------------------
	// Compare
	// ----------------------------------------------------------------
	wire                           active    = enable_q & link_valid_100;   // [R1]
	logic [lqm_pkg::WARN_W-1:0]    viol;
	logic [lqm_pkg::WARN_W-1:0]    disabled;
	logic [lqm_pkg::NPARAM-1:0]    restart_hit;

	for (genvar i = 0; i < lqm_pkg::NPARAM; i++) begin : g_param
		// Extreme thresholds are off; low and high judged separately
		assign disabled[2*i]     = (thr_lo_q[i] == lqm_pkg::THR_LOW_MIN);   // [R2]
		assign disabled[2*i+1]   = (thr_hi_q[i] == lqm_pkg::THR_HIGH_MAX);  // [R2]
		assign viol[2*i]         = active & ~disabled[2*i]
			& (dsp_values.val[i] < thr_lo_q[i]);                            // [R18]
		assign viol[2*i+1]       = active & ~disabled[2*i+1]
			& (dsp_values.val[i] > thr_hi_q[i]);                            // [R18]
		// Restart once per new warning of this parameter
		assign restart_hit[i]    = restart_en_q[i]
			& |(viol[2*i +: 2] & ~warn_q[2*i +: 2]);                        // [R5] [R6] [R7] [R8] [R9]

		always_ff @(posedge ref_clk or negedge rst_n_q) begin
			if (!rst_n_q) begin
				thr_lo_q[i] <= lqm_pkg::THR_LOW_MIN;
				thr_hi_q[i] <= lqm_pkg::THR_HIGH_MAX;
			end else if (wr_thr && wr_sel == 3'(i)) begin                  // [R16]
				if (wr_lvl)
					thr_hi_q[i] <= wr_val;
				else
					thr_lo_q[i] <= wr_val;
			end
		end
	end

	// ----------------------------------------------------------------
	// Warnings, interrupt, restart
	// ----------------------------------------------------------------
	// New violation wins over the clearing read
	assign warn_d      = (rd_ctrl ? '0 : warn_q) | viol;                     // [R4] [R11] [R12] [R13] [R14] [R15] [R17]
	wire   viol_event  = armed_q & (|viol);
	wire   restart_any = |restart_hit;
	assign armed_d     = rd_ctrl | (armed_q & ~viol_event);                  // [R4]
	assign istat_d     = (istat_q & ~(wr_istat ? bus_req.wdata[lqm_pkg::IRQ_W-1:0] : '0))
		| {restart_any, viol_event};

	wire [lqm_pkg::VAL_W-1:0] sel_thr = (thr_sel_q >= 3'(lqm_pkg::NPARAM)) ? '0 :
		thr_lvl_q ? thr_hi_q[thr_sel_q] : thr_lo_q[thr_sel_q];

	assign rdata_d = !bus_req.re ? '0 :
		hit(bus_req.addr, lqm_pkg::ADDR_CTRL_STATUS) ?
			{enable_q, restart_en_q, warn_q} :
		hit(bus_req.addr, lqm_pkg::ADDR_THRESHOLD) ?
			{4'h0, thr_sel_q, thr_lvl_q, sel_thr} :
		hit(bus_req.addr, lqm_pkg::ADDR_IRQ_STATUS) ?
			{{(lqm_pkg::DATA_W-lqm_pkg::IRQ_W){1'b0}}, istat_q} :
		hit(bus_req.addr, lqm_pkg::ADDR_IRQ_MASK) ?
			{{(lqm_pkg::DATA_W-lqm_pkg::IRQ_W){1'b0}}, imask_q} : '0;

	// Software-written control
	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			enable_q     <= 1'b0;
			restart_en_q <= '0;
		end else if (wr_ctrl) begin
			enable_q     <= bus_req.wdata[lqm_pkg::BIT_ENABLE];
			restart_en_q <= bus_req.wdata[lqm_pkg::RESTART_LSB +: lqm_pkg::NPARAM];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			thr_sel_q <= 3'h0;
			thr_lvl_q <= 1'b0;
		end else if (wr_thr) begin
			thr_sel_q <= wr_sel;
			thr_lvl_q <= wr_lvl;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q)
			imask_q <= '0;
		else if (wr_imask)
			imask_q <= bus_req.wdata[lqm_pkg::IRQ_W-1:0];
	end

	// Sticky status
	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			warn_q  <= '0;
			armed_q <= 1'b1;
			istat_q <= '0;
		end else begin
			warn_q  <= warn_d;
			armed_q <= armed_d;
			istat_q <= istat_d;
		end
	end

	// Registered outputs
	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rdata_q   <= '0;
			restart_q <= 1'b0;
			drop_q    <= 1'b0;
		end else begin
			rdata_q   <= rdata_d;
			restart_q <= restart_any;                                         // [R5] [R6] [R7] [R8] [R9]
			drop_q    <= restart_any & ~signal_detect_option;                 // [R10]
		end
	end

	assign bus_rdata   = rdata_q;
	assign dsp_restart = restart_q;
	assign link_drop   = drop_q;
	assign irq         = |(istat_q & imask_q);                                // [R3]

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n_q);

	property p_restart(int k);
		restart_en_q[k] && viol[2*k] && !warn_q[2*k] |=> dsp_restart;
	endproperty

	property p_warn_set(int k);
		viol[k] |=> warn_q[k] [*2] or (warn_q[k] ##1 $past(rd_ctrl));
	endproperty

	property p_restart_hi(int k);
		restart_en_q[k] && viol[2*k+1] && !warn_q[2*k+1] |=> dsp_restart;
	endproperty

	property p_low_seen(int k);
		active && thr_lo_q[k] != lqm_pkg::THR_LOW_MIN
			&& dsp_values.val[k] < thr_lo_q[k] |=> warn_q[2*k];
	endproperty

	property p_high_seen(int k);
		active && thr_hi_q[k] != lqm_pkg::THR_HIGH_MAX
			&& dsp_values.val[k] > thr_hi_q[k] |=> warn_q[2*k+1];
	endproperty

	property p_extreme_off(int k);
		thr_lo_q[k] == lqm_pkg::THR_LOW_MIN && thr_hi_q[k] == lqm_pkg::THR_HIGH_MAX
			&& !rd_ctrl |=> warn_q[2*k +: 2] == $past(warn_q[2*k +: 2]);
	endproperty

	AST_NO_LINK_NO_MON: assert property (!link_valid_100 |-> viol == '0)     // [R1]
		else $error("Violation seen without a valid link");
	AST_EXTREME_OFF: assert property ((viol & disabled) == '0)             // [R2]
		else $error("Disabled threshold produced a violation");
	AST_IRQ_MASKED: assert property (viol_event && imask_q[lqm_pkg::IRQ_BIT_VIOL]
		|=> irq ##1 (irq || $past(wr_istat)))                              // [R3]
		else $error("Unmasked violation did not raise interrupt");
	AST_IRQ_QUIET: assert property (imask_q == '0 |-> !irq)                // [R3]
		else $error("Interrupt raised while fully masked");
	AST_READ_CLEARS: assert property (rd_ctrl && viol == '0 |=> warn_q == '0 && armed_q) // [R4]
		else $error("Control read did not clear warnings");
	AST_NO_REARM: assert property (viol_event && !rd_ctrl |=> !armed_q)   // [R4]
		else $error("Interrupt re-armed without a read");
	AST_RESTART_EQ: assert property (p_restart(0))                         // [R9]
		else $error("Equalizer violation missed restart");
	AST_RESTART_GAIN: assert property (p_restart(1))                       // [R8]
		else $error("Gain violation missed restart");
	AST_RESTART_BLW: assert property (p_restart(2))                        // [R7]
		else $error("Baseline wander violation missed restart");
	AST_RESTART_FOFF: assert property (p_restart(3))                       // [R6]
		else $error("Frequency offset violation missed restart");
	AST_RESTART_FCTL: assert property (p_restart(4))                       // [R5]
		else $error("Frequency control violation missed restart");
	AST_NO_RESTART: assert property (restart_en_q == '0 |=> !dsp_restart)  // [R5]
		else $error("Restart without an enabled source");
	AST_LINK_DROP: assert property (dsp_restart |-> link_drop == !$past(signal_detect_option)) // [R10]
		else $error("Link drop disagrees with signal-detect option");
	AST_WARN_FCTL: assert property (viol[9] || viol[8] |=> warn_q[9:8] != 2'h0) // [R11]
		else $error("Frequency control warning not set");
	AST_WARN_FOFF: assert property (viol[7] || viol[6] |=> warn_q[7:6] != 2'h0) // [R12]
		else $error("Frequency offset warning not set");
	AST_WARN_BLW: assert property (viol[5] || viol[4] |=> warn_q[5:4] != 2'h0) // [R13]
		else $error("Baseline wander warning not set");
	AST_WARN_GAIN: assert property (viol[3] || viol[2] |=> warn_q[3:2] != 2'h0) // [R14]
		else $error("Gain warning not set");
	AST_WARN_EQ: assert property (viol[1] || viol[0] |=> warn_q[1:0] != 2'h0) // [R15]
		else $error("Equalizer warning not set");
	AST_THR_WRITE: assert property (wr_thr && wr_sel == 3'h4 && wr_lvl
		|=> thr_hi_q[4] == $past(wr_val))                                  // [R16]
		else $error("High threshold write went astray");
	AST_WARN_HOLD: assert property (warn_q != '0 && !rd_ctrl |=> (warn_q & $past(warn_q))
		== $past(warn_q))                                                  // [R17]
		else $error("Warning dropped without a read");
	AST_LOW_INDEP: assert property (active && !disabled[0]
		&& dsp_values.val[0] < thr_lo_q[0] |-> viol[0])                    // [R18]
		else $error("Low limit compare missed");

	AST_RESTART_EQ_HI: assert property (p_restart_hi(0))                   // [R9]
		else $error("Equalizer high violation missed restart");
	AST_RESTART_GAIN_HI: assert property (p_restart_hi(1))                 // [R8]
		else $error("Gain high violation missed restart");
	AST_RESTART_BLW_HI: assert property (p_restart_hi(2))                  // [R7]
		else $error("Baseline wander high violation missed restart");
	AST_RESTART_FOFF_HI: assert property (p_restart_hi(3))                 // [R6]
		else $error("Frequency offset high violation missed restart");
	AST_RESTART_FCTL_HI: assert property (p_restart_hi(4))                 // [R5]
		else $error("Frequency control high violation missed restart");
	AST_LOW_SEEN_GAIN: assert property (p_low_seen(1))                     // [R14] [R18]
		else $error("Gain low warning missed");
	AST_LOW_SEEN_BLW: assert property (p_low_seen(2))                      // [R13] [R18]
		else $error("Baseline wander low warning missed");
	AST_LOW_SEEN_FOFF: assert property (p_low_seen(3))                     // [R12] [R18]
		else $error("Frequency offset low warning missed");
	AST_LOW_SEEN_FCTL: assert property (p_low_seen(4))                     // [R11] [R18]
		else $error("Frequency control low warning missed");
	AST_HIGH_SEEN_EQ: assert property (p_high_seen(0))                     // [R15] [R18]
		else $error("Equalizer high warning missed");
	AST_HIGH_SEEN_GAIN: assert property (p_high_seen(1))                   // [R14] [R18]
		else $error("Gain high warning missed");
	AST_HIGH_SEEN_BLW: assert property (p_high_seen(2))                    // [R13] [R18]
		else $error("Baseline wander high warning missed");
	AST_HIGH_SEEN_FOFF: assert property (p_high_seen(3))                   // [R12] [R18]
		else $error("Frequency offset high warning missed");
	AST_HIGH_SEEN_FCTL: assert property (p_high_seen(4))                   // [R11] [R18]
		else $error("Frequency control high warning missed");
	AST_EXTREME_OFF_EQ: assert property (p_extreme_off(0))                 // [R2]
		else $error("Equalizer warning set with both limits off");
	AST_EXTREME_OFF_GAIN: assert property (p_extreme_off(1))               // [R2]
		else $error("Gain warning set with both limits off");
	AST_EXTREME_OFF_BLW: assert property (p_extreme_off(2))                // [R2]
		else $error("Baseline wander warning set with both limits off");
	AST_EXTREME_OFF_FOFF: assert property (p_extreme_off(3))               // [R2]
		else $error("Frequency offset warning set with both limits off");
	AST_EXTREME_OFF_FCTL: assert property (p_extreme_off(4))               // [R2]
		else $error("Frequency control warning set with both limits off");
	AST_NO_MON_DISABLED: assert property (!enable_q |-> viol == '0)        // [R1]
		else $error("Violation seen while monitor disabled");
	AST_READ_LEAVES_NEW: assert property (rd_ctrl |=> warn_q == $past(viol)) // [R4]
		else $error("Control read left stale warnings");
	AST_WARN_NEEDS_VIOL: assert property ((warn_q & ~$past(warn_q) & ~$past(viol)) == '0) // [R11]
		else $error("Warning set without a violation");
	AST_DROP_NEEDS_RESTART: assert property (link_drop |-> dsp_restart)   // [R10]
		else $error("Link dropped without a restart");
	AST_ISTAT_VIOL: assert property (viol_event |=> istat_q[lqm_pkg::IRQ_BIT_VIOL]) // [R3]
		else $error("Violation event not recorded");
	AST_ISTAT_RESTART: assert property (restart_any |=> istat_q[lqm_pkg::IRQ_BIT_RESTART]) // [R5]
		else $error("Restart event not recorded");
	AST_THR_WRITE_LOW: assert property (wr_thr && wr_sel == 3'h0 && !wr_lvl // [R16]
		|=> thr_lo_q[0] == $past(wr_val))
		else $error("Low threshold write went astray");
	AST_THR_SEL_REFUSED: assert property (wr_thr && wr_sel >= 3'(lqm_pkg::NPARAM) // [R16]
		|=> thr_hi_q[4] == $past(thr_hi_q[4]) && thr_lo_q[4] == $past(thr_lo_q[4]))
		else $error("Out-of-range select changed a threshold");
	AST_WARN_STICKY: assert property (p_warn_set(9))                       // [R17]
		else $error("Frequency control high warning did not stick");

	COV_VIOL_IRQ: cover property (viol_event ##1 irq);
	COV_RESTART_DROP: cover property (dsp_restart && link_drop);
	COV_READ_REARM: cover property (!armed_q ##1 rd_ctrl ##1 armed_q);
	COV_EXTREME_SET: cover property (wr_thr && wr_lvl && wr_val == lqm_pkg::THR_HIGH_MAX);
	COV_NO_LINK: cover property (enable_q && !link_valid_100);
endmodule

// ==== hw/lqm_pkg.sv ====
// Constants, types and register map of the link quality monitor.
// Assumes one 100 MHz clock shared with the receiver DSP and link logic.
//
// What this block does
// R1: Monitoring runs only while enabled and a valid 100 Mb link exists.
// R2: A threshold at its range extreme (max high, min low) never violates.
// R3: A violation raises the interrupt only when its mask bit is set.
// R4: Reading control/status clears all warnings and re-arms the interrupt.
// R5: Frequency control violation with its restart bit restarts DSP adaption.
// R6: Frequency offset violation with its restart bit restarts DSP adaption.
// R7: Baseline wander violation with its restart bit restarts DSP adaption.
// R8: Digital gain violation with its restart bit restarts DSP adaption.
// R9: Equalizer coefficient violation with its restart bit restarts DSP adaption.
// R10: A restart also drops link status unless signal-detect option is set.
// R11: Frequency control high and low warnings set on violation, clear on read.
// R12: Frequency offset high and low warnings set on violation, clear on read.
// R13: Baseline wander high and low warnings set on violation, clear on read.
// R14: Digital gain high and low warnings set on violation, clear on read.
// R15: Equalizer coefficient high and low warnings set on violation, clear on read.
// R16: Parameter codes 000 to 100; level bit 0 low, 1 high threshold.
// R17: A warning stays set until the next control/status read.
// R18: Low and high limits are compared independently and continuously.

package lqm_pkg;
	localparam int          ADDR_W  = 8;
	localparam int          DATA_W  = 16;
	localparam int          VAL_W   = 8;
	localparam int          NPARAM  = 5;
	localparam int          WARN_W  = 2 * NPARAM;
	localparam int          IRQ_W   = 2;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0]  ADDR_CTRL_STATUS = 8'h1d;
	localparam logic [7:0]  ADDR_THRESHOLD   = 8'h20;
	localparam logic [7:0]  ADDR_IRQ_STATUS  = 8'h21;
	localparam logic [7:0]  ADDR_IRQ_MASK    = 8'h22;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int          BIT_ENABLE       = 15;
	localparam int          RESTART_LSB      = 10;
	localparam int          THR_SEL_LSB      = 9;
	localparam int          THR_LVL_BIT      = 8;
	localparam int          IRQ_BIT_VIOL     = 0;
	localparam int          IRQ_BIT_RESTART  = 1;

	// ----------------------------------------------------------------
	// Reset values and extremes
	// ----------------------------------------------------------------
	localparam logic [7:0]  THR_LOW_MIN      = 8'h00;
	localparam logic [7:0]  THR_HIGH_MAX     = 8'hff;

	typedef enum logic [2:0] {
		PARAM_EQ_COEFF, PARAM_DIG_GAIN, PARAM_BASE_WANDER, PARAM_FREQ_OFFSET, PARAM_FREQ_CTRL
	} lqm_param_e_t;

	typedef logic [VAL_W-1:0] lqm_val_t;

	typedef struct packed {
		lqm_val_t [NPARAM-1:0] val;
	} lqm_dsp_t;

	typedef struct packed {
		logic              we;
		logic              re;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} lqm_bus_req_t;
endpackage

// ==== verification/link_quality_monitor_tb_top.sv ====
// Self-checking testbench for the link quality monitor.
// Assumes lqm_pkg and lqm_monitor are compiled first; one 100 MHz clock.
`timescale 1ns/1ns

module link_quality_monitor_tb_top;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic                        ref_clk;
	logic                        reset_n;
	lqm_pkg::lqm_bus_req_t       bus_req;
	logic [lqm_pkg::DATA_W-1:0]  bus_rdata;
	lqm_pkg::lqm_dsp_t           dsp_values;
	logic                        link_valid_100;
	logic                        signal_detect_option;
	logic                        dsp_restart;
	logic                        link_drop;
	logic                        irq;
	int                          n_mismatch;
	int                          cmp_count;
	int                          n_rst;
	int                          n_drop;
	int                          rs0;
	int                          dr0;
	logic [15:0]                 ctrl_w;

	lqm_monitor dut_u (
		.ref_clk              (ref_clk),
		.reset_n              (reset_n),
		.bus_req              (bus_req),
		.bus_rdata            (bus_rdata),
		.dsp_values           (dsp_values),
		.link_valid_100       (link_valid_100),
		.signal_detect_option (signal_detect_option),
		.dsp_restart          (dsp_restart),
		.link_drop            (link_drop),
		.irq                  (irq)
	);

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// Count restart and link drop pulses
	always @(posedge ref_clk) begin
		if (dsp_restart === 1'b1) n_rst++;
		if (link_drop === 1'b1) n_drop++;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		bus_req.we    <= 1'b1;
		bus_req.addr  <= a;
		bus_req.wdata <= d;
		@(posedge ref_clk);
		bus_req.we    <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string nm);
		@(posedge ref_clk);
		bus_req.re   <= 1'b1;
		bus_req.addr <= a;
		@(posedge ref_clk);
		bus_req.re   <= 1'b0;
		#1;
		chk(nm, exp, bus_rdata);
	endtask

	task automatic thr(input int p, input logic lvl, input logic [7:0] v);
		wr(lqm_pkg::ADDR_THRESHOLD, {4'h0, p[2:0], lvl, v});
	endtask

	// Hold a parameter value out of range, then bring it back
	task automatic pulse_val(input int p, input logic [7:0] v);
		@(posedge ref_clk);
		dsp_values.val[p] <= v;
		cyc(3);
		dsp_values.val[p] <= 8'h80;
		cyc(2);
		#1;
	endtask

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		#50000;
		n_mismatch++;
		finish_test;
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		reset_n = 1'b0;
		link_valid_100 = 1'b1;
		signal_detect_option = 1'b0;
		bus_req = '0;
		dsp_values = {5{8'h80}};
		n_mismatch = 0;
		cmp_count = 0;
		n_rst = 0;
		n_drop = 0;
		cyc(5);
		reset_n <= 1'b1;
		cyc(3);
		rd(lqm_pkg::ADDR_CTRL_STATUS, 16'h0000, "ctrl reset");
		rd(lqm_pkg::ADDR_IRQ_MASK, 16'h0000, "mask reset");
		rd(lqm_pkg::ADDR_IRQ_STATUS, 16'h0000, "status reset");
		rd(8'h05, 16'h0000, "unmapped");
		wr(lqm_pkg::ADDR_THRESHOLD, 16'h0a12);
		rd(lqm_pkg::ADDR_THRESHOLD, 16'h0a00, "sel refused");
		$display("test reset_values done");
		for (int i = 0; i < 5; i++) begin
			ctrl_w = 16'h8000 | ((i % 2) ? (16'h0001 << (10 + i)) : 16'h0000);
			rs0 = n_rst;
			dr0 = n_drop;
			wr(lqm_pkg::ADDR_CTRL_STATUS, ctrl_w);
			signal_detect_option <= i[1];
			thr(i, 1'b0, 8'h40);
			thr(i, 1'b1, 8'hc0);
			rd(lqm_pkg::ADDR_THRESHOLD, {4'h0, i[2:0], 1'b1, 8'hc0}, "thr readback");
			pulse_val(i, 8'h30);
			chk("irq masked", {15'h0, i > 0}, {15'h0, irq});
			rd(lqm_pkg::ADDR_CTRL_STATUS, ctrl_w | (16'h1 << (2 * i)), "low warn");
			rd(lqm_pkg::ADDR_IRQ_STATUS, {14'h0, i[0], 1'b1}, "irq status");
			wr(lqm_pkg::ADDR_IRQ_STATUS, 16'h0003);
			if (i == 0)
				wr(lqm_pkg::ADDR_IRQ_MASK, 16'h0003);
			pulse_val(i, 8'hd0);
			chk("irq rearmed", 16'h0001, {15'h0, irq});
			rd(lqm_pkg::ADDR_CTRL_STATUS, ctrl_w | (16'h2 << (2 * i)), "high warn");
			rd(lqm_pkg::ADDR_CTRL_STATUS, ctrl_w, "warn cleared");
			wr(lqm_pkg::ADDR_IRQ_STATUS, 16'h0003);
			cyc(2);
			#1;
			chk("irq cleared", 16'h0000, {15'h0, irq});
			chk("restarts", 16'((i % 2) ? 2 : 0), 16'(n_rst - rs0));
			chk("link drops", 16'(((i % 2) && !i[1]) ? 2 : 0), 16'(n_drop - dr0));
			thr(i, 1'b0, 8'h00);
			thr(i, 1'b1, 8'hff);
			pulse_val(i, 8'h00);
			pulse_val(i, 8'hff);
			rd(lqm_pkg::ADDR_CTRL_STATUS, ctrl_w, "extreme off");
			$display("test param %0d done", i);
		end
		@(posedge ref_clk);
		link_valid_100 <= 1'b0;
		wr(lqm_pkg::ADDR_CTRL_STATUS, 16'h8000);
		thr(0, 1'b0, 8'h40);
		pulse_val(0, 8'h30);
		rd(lqm_pkg::ADDR_CTRL_STATUS, 16'h8000, "no link");
		@(posedge ref_clk);
		link_valid_100 <= 1'b1;
		wr(lqm_pkg::ADDR_CTRL_STATUS, 16'h0000);
		pulse_val(0, 8'h30);
		rd(lqm_pkg::ADDR_CTRL_STATUS, 16'h0000, "disabled");
		$display("test link_gate done");
		finish_test;
	end
endmodule
